/* File: core/t1dp_params.svh */
`ifndef T1DP_PARAMS_SVH
`define T1DP_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define T1DP_CLK_MHZ 25
`define T1DP_IDLE_NS 2000
`define T1DP_IDLE_CYC ((`T1DP_IDLE_NS * `T1DP_CLK_MHZ) / 1000)
// ----------------------------------------
// Register offsets and responses
// ----------------------------------------
`define T1DP_AW 8
`define T1DP_OFS_CTRL3 8'h00
`define T1DP_OFS_STATUS 8'h04
`define T1DP_OFS_ISTAT 8'h08
`define T1DP_OFS_IMASK 8'h0c
`define T1DP_RESP_OKAY 2'h0
`define T1DP_RESP_SLVERR 2'h2
// ----------------------------------------
// Control fields, events, pin slots
// ----------------------------------------
`define T1DP_C_UNI 0
`define T1DP_C_QRSS 1
`define T1DP_C_LLOC 2
`define T1DP_C_LREM 3
`define T1DP_C_EDGE 4
`define T1DP_CTRL_RST 5'h00
`define T1DP_EV_VIOL 0
`define T1DP_EV_TXLOST 1
`define T1DP_EV_LOSS 2
`define T1DP_NEV 3
`define T1DP_PIN_TP 0
`define T1DP_PIN_TN 1
`define T1DP_PIN_LP 2
`define T1DP_PIN_LN 3
`define T1DP_PIN_LOS 4
`define T1DP_NPIN 5
// ----------------------------------------
// Pattern generator
// ----------------------------------------
`define T1DP_PRBS_W 20
`define T1DP_PRBS_TAP 17
`define T1DP_PRBS_SEED 20'h00001
`endif

/* File: core/t1dp_pin_mon.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t1dp_params.svh"
module t1dp_pin_mon
	import t1dp_pkg::*;
#(
	parameter int IDLE_CYC = `T1DP_IDLE_CYC
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Watched pin
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall,
	output logic o_active
);
	localparam int CW = $clog2(IDLE_CYC + 1);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [CW-1:0] idle;
		logic active;
	} t1dp_mon_s;
	t1dp_mon_s q;
	t1dp_mon_s d;
	// ----------------------------------------
	// Synchroniser, edges and activity window
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.s1 = i_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 != q.s3)
		begin
			d.idle = '0;
			d.active = 1'b1;
		end
		else if (q.idle == CW'(IDLE_CYC))
			d.active = 1'b0;
		else
			d.idle = q.idle + 1'b1;
	end
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			q <= '0;
		else if (i_ce)
			q <= d;
	end
	assign o_level = q.s2;
	assign o_rise = q.s2 & ~q.s3;
	assign o_fall = ~q.s2 & q.s3;
	assign o_active = q.active;
endmodule
`default_nettype wire

/* File: core/t1dp_pkg.sv */
`include "t1dp_params.svh"
package t1dp_pkg;
	typedef struct packed {
		logic awvalid;
		logic [`T1DP_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`T1DP_AW-1:0] araddr;
		logic rready;
	} t1dp_axi_req_s;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} t1dp_axi_rsp_s;
	typedef struct packed {
		logic edge_sel;
		logic lb_remote;
		logic lb_local;
		logic qrss;
		logic unipolar;
	} t1dp_ctrl_s;
	typedef struct packed {
		t1dp_axi_rsp_s rsp;
		logic aw_full;
		logic [`T1DP_AW-1:0] awaddr;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		t1dp_ctrl_s ctrl;
		logic [`T1DP_NEV-1:0] istat;
		logic [`T1DP_NEV-1:0] imask;
		logic irq;
		logic [`T1DP_NPIN-1:0] pin_s1;
		logic [`T1DP_NPIN-1:0] pin_s2;
		logic ler_prev;
		logic bpv_prev;
		logic bpv_pend;
		logic tx_pol;
		logic loop_pos;
		logic loop_neg;
		logic line_pos;
		logic line_neg;
		logic cap_pos;
		logic cap_neg;
		logic cap_viol;
		logic rx_pol;
		logic rx_pos;
		logic rx_neg;
		logic rx_clk;
		logic tck_was;
		logic los_was;
	} t1dp_state_s;
endpackage

/* File: core/t1dp_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t1dp_params.svh"
module t1dp_port
	import t1dp_pkg::*;
#(
	parameter int IDLE_CYC = `T1DP_IDLE_CYC
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Register bus
	input wire t1dp_axi_req_s i_axi,
	output t1dp_axi_rsp_s o_axi,
	// System side clocks and data
	input wire logic i_mclk,
	input wire logic i_transmit_clock,
	input wire logic i_tx_positive,
	input wire logic i_tx_negative,
	output logic o_rx_positive,
	output logic o_rx_negative,
	output logic o_rx_clock,
	// Line side
	input wire logic i_line_clock,
	input wire logic i_line_pos,
	input wire logic i_line_neg,
	input wire logic i_signal_loss,
	output logic o_line_pos,
	output logic o_line_neg,
	// Interrupt
	output logic o_irq
);
	t1dp_state_s q;
	t1dp_state_s d;
	logic mc_lvl;
	logic mc_rise;
	logic mc_fall;
	logic tc_lvl;
	logic tc_rise;
	logic tc_fall;
	logic tc_act;
	logic lc_lvl;
	logic lc_rise;
	logic lc_fall;
	logic prbs_bit;
	logic prbs_step;
	// ----------------------------------------
	// Clock monitors and pattern generator
	// ----------------------------------------
	t1dp_pin_mon #(.IDLE_CYC(IDLE_CYC)) u_mclk
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_pin(i_mclk),
		.o_level(mc_lvl),
		.o_rise(mc_rise),
		.o_fall(mc_fall),
		.o_active()
	);
	t1dp_pin_mon #(.IDLE_CYC(IDLE_CYC)) u_transmit_clock
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_pin(i_transmit_clock),
		.o_level(tc_lvl),
		.o_rise(tc_rise),
		.o_fall(tc_fall),
		.o_active(tc_act)
	);
	t1dp_pin_mon #(.IDLE_CYC(IDLE_CYC)) u_lclk
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_pin(i_line_clock),
		.o_level(lc_lvl),
		.o_rise(lc_rise),
		.o_fall(lc_fall),
		.o_active()
	);
	t1dp_prbs u_prbs
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_step(prbs_step),
		.o_bit(prbs_bit)
	);
	// ----------------------------------------
	// Clock selection
	// ----------------------------------------
	logic tx_lvl;
	logic tx_rise;
	logic tx_strobe;
	logic rs_lvl;
	logic rs_rise;
	logic rs_fall;
	logic signal_loss;
	always_comb
	begin
		signal_loss = q.pin_s2[`T1DP_PIN_LOS];
		tx_lvl = tc_act ? tc_lvl : mc_lvl;
		tx_rise = tc_act ? tc_rise : mc_rise;
		tx_strobe = tc_act ? tc_fall : mc_fall;
		if (signal_loss)
		begin
			rs_lvl = mc_lvl;
			rs_rise = mc_rise;
			rs_fall = mc_fall;
		end
		else if (q.ctrl.lb_local)
		begin
			rs_lvl = tx_lvl;
			rs_rise = tx_rise;
			rs_fall = tx_strobe;
		end
		else
		begin
			rs_lvl = lc_lvl;
			rs_rise = lc_rise;
			rs_fall = lc_fall;
		end
	end
	assign prbs_step = tx_strobe & q.ctrl.qrss;
	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	logic tp;
	logic tn;
	logic ler_in;
	logic bpv_in;
	logic ler_rise;
	logic bpv_rise;
	logic mark;
	logic vio;
	logic pol;
	logic sp;
	logic sn;
	always_comb
	begin
		tp = q.pin_s2[`T1DP_PIN_TP];
		tn = q.pin_s2[`T1DP_PIN_TN];
		ler_in = q.ctrl.qrss & tp;
		bpv_in = (q.ctrl.unipolar | q.ctrl.qrss) & tn;
		ler_rise = ler_in & ~q.ler_prev;
		bpv_rise = bpv_in & ~q.bpv_prev;
		mark = q.ctrl.qrss ? (prbs_bit ^ ler_rise) : tp;
		vio = q.bpv_pend | bpv_rise;
		pol = vio ? q.tx_pol : ~q.tx_pol;
		if (!q.ctrl.qrss && !q.ctrl.unipolar)
		begin
			sp = tp;
			sn = tn;
		end
		else
		begin
			sp = mark & pol;
			sn = mark & ~pol;
		end
	end
	// ----------------------------------------
	// Receive capture
	// ----------------------------------------
	logic cp;
	logic cn;
	logic cviol;
	always_comb
	begin
		cp = q.ctrl.lb_local ? q.loop_pos : q.pin_s2[`T1DP_PIN_LP];
		cn = q.ctrl.lb_local ? q.loop_neg : q.pin_s2[`T1DP_PIN_LN];
		cviol = (cp & cn) | ((cp | cn) & (cp == q.rx_pol));
	end
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [`T1DP_NEV-1:0] ev;
	logic [`T1DP_NEV-1:0] clr;
	logic [31:0] rd;
	logic rd_ok;
	always_comb
	begin
		d = q;
		ev = '0;
		clr = '0;
		rd = '0;
		rd_ok = 1'b1;
		d.pin_s1 = {i_signal_loss, i_line_neg, i_line_pos,
			i_tx_negative, i_tx_positive};
		d.pin_s2 = q.pin_s1;
		// Transmit sampling
		if (tx_strobe)
		begin
			d.ler_prev = ler_in;
			d.bpv_prev = bpv_in;
			if (!q.ctrl.qrss && !q.ctrl.unipolar)
				d.bpv_pend = 1'b0;
			else if (mark)
			begin
				d.tx_pol = pol;
				d.bpv_pend = 1'b0;
			end
			else
				d.bpv_pend = vio;
			d.loop_pos = sp;
			d.loop_neg = sn;
			if (q.ctrl.lb_remote)
			begin
				d.line_pos = q.cap_pos;
				d.line_neg = q.cap_neg;
			end
			else
			begin
				d.line_pos = sp;
				d.line_neg = sn;
			end
		end
		// Receive side
		d.rx_clk = rs_lvl;
		if (rs_rise)
		begin
			d.cap_pos = cp;
			d.cap_neg = cn;
			d.cap_viol = cviol;
			ev[`T1DP_EV_VIOL] = cviol;
			if (cp | cn)
				d.rx_pol = cp;
		end
		if (q.ctrl.edge_sel ? rs_rise : rs_fall)
		begin
			if (q.ctrl.unipolar)
				d.rx_pos = q.cap_pos | q.cap_neg;
			else
			begin
				d.rx_pos = q.cap_pos;
				d.rx_neg = q.cap_neg;
			end
		end
		if (rs_fall && q.ctrl.unipolar)
			d.rx_neg = q.cap_viol;
		// Events
		d.tck_was = tc_act;
		d.los_was = signal_loss;
		ev[`T1DP_EV_TXLOST] = q.tck_was & ~tc_act;
		ev[`T1DP_EV_LOSS] = signal_loss & ~q.los_was;
		// Write channel
		if (i_axi.awvalid && q.rsp.awready)
		begin
			d.aw_full = 1'b1;
			d.awaddr = i_axi.awaddr;
		end
		if (i_axi.wvalid && q.rsp.wready)
		begin
			d.w_full = 1'b1;
			d.wdata = i_axi.wdata;
			d.wstrb = i_axi.wstrb;
		end
		if (q.rsp.bvalid && i_axi.bready)
			d.rsp.bvalid = 1'b0;
		if (q.aw_full && q.w_full && !q.rsp.bvalid)
		begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = `T1DP_RESP_OKAY;
			unique case (q.awaddr)
				`T1DP_OFS_CTRL3:
				begin
					if (q.wstrb[0])
						d.ctrl = q.wdata[4:0];
				end
				`T1DP_OFS_STATUS:
				begin
				end
				`T1DP_OFS_ISTAT:
				begin
					if (q.wstrb[0])
						clr = q.wdata[`T1DP_NEV-1:0];
				end
				`T1DP_OFS_IMASK:
				begin
					if (q.wstrb[0])
						d.imask = q.wdata[`T1DP_NEV-1:0];
				end
				default:
					d.rsp.bresp = `T1DP_RESP_SLVERR;
			endcase
		end
		d.rsp.awready = ~d.aw_full & ~d.rsp.bvalid;
		d.rsp.wready = ~d.w_full & ~d.rsp.bvalid;
		// Read channel
		unique case (i_axi.araddr)
			`T1DP_OFS_CTRL3:
				rd = {27'h0, q.ctrl};
			`T1DP_OFS_STATUS:
				rd = {29'h0, signal_loss, q.ctrl.lb_local, tc_act};
			`T1DP_OFS_ISTAT:
				rd = {29'h0, q.istat};
			`T1DP_OFS_IMASK:
				rd = {29'h0, q.imask};
			default:
				rd_ok = 1'b0;
		endcase
		if (q.rsp.rvalid && i_axi.rready)
			d.rsp.rvalid = 1'b0;
		if (i_axi.arvalid && q.rsp.arready)
		begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata = rd;
			d.rsp.rresp = rd_ok ? `T1DP_RESP_OKAY : `T1DP_RESP_SLVERR;
		end
		d.rsp.arready = ~d.rsp.rvalid;
		// Sticky status, set wins over clear
		d.istat = (q.istat & ~clr) | ev;
		d.irq = |(d.istat & d.imask);
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			q <= '0;
			q.ctrl <= `T1DP_CTRL_RST;
		end
		else if (i_ce)
			q <= d;
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_axi = q.rsp;
	assign o_rx_positive = q.rx_pos;
	assign o_rx_negative = q.rx_neg;
	assign o_rx_clock = q.rx_clk;
	assign o_line_pos = q.line_pos;
	assign o_line_neg = q.line_neg;
	assign o_irq = q.irq;
endmodule
`default_nettype wire

/* File: core/t1dp_prbs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t1dp_params.svh"
module t1dp_prbs
	import t1dp_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Pattern
	input wire logic i_step,
	output logic o_bit
);
	logic [`T1DP_PRBS_W-1:0] q;
	logic [`T1DP_PRBS_W-1:0] d;
	// ----------------------------------------
	// Test pattern shift register
	// ----------------------------------------
	always_comb
	begin
		d = q;
		if (i_step)
			d = {q[`T1DP_PRBS_W-2:0],
				q[`T1DP_PRBS_W-1] ^ q[`T1DP_PRBS_TAP-1]};
	end
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			q <= `T1DP_PRBS_SEED;
		else if (i_ce)
			q <= d;
	end
	assign o_bit = q[`T1DP_PRBS_W-1];
endmodule
`default_nettype wire

/* File: verif/t1dp_framer_model.sv */
`timescale 1ns/1ns
`default_nettype none
module t1dp_framer_model
(
	// Bench control
	input wire logic i_run,
	input wire logic [1:0] i_bits,
	// Transmit pins
	output logic o_transmit_clock,
	output logic o_pos,
	output logic o_neg
);
	logic [1:0] held = 2'b00;
	// Clock stands low outside frames
	initial
	begin
		o_transmit_clock = 1'b0;
		forever
		begin
			#160;
			if (i_run || o_transmit_clock)
				o_transmit_clock = !o_transmit_clock;
		end
	end
	// Marks launched on the rise, held over the falling sample
	always @(posedge o_transmit_clock)
		held <= i_bits;
	assign o_pos = i_run ? held[1] : i_bits[1];
	assign o_neg = i_run ? held[0] : i_bits[0];
endmodule
`default_nettype wire

/* File: verif/t1dp_port_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module t1dp_port_properties
	import t1dp_pkg::*;
#(
	parameter int IDLE_CYC = 50
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Register bus
	input wire t1dp_axi_req_s i_axi,
	input wire t1dp_axi_rsp_s o_axi,
	// Pins
	input wire logic i_mclk,
	input wire logic i_transmit_clock,
	input wire logic i_signal_loss,
	input wire logic o_rx_clock,
	input wire logic o_line_pos,
	input wire logic o_line_neg,
	input wire logic o_irq
);
	logic [3:0] fall_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Cycles since a sampling clock fell
	always_ff @(posedge i_clk or negedge i_rst_b)
		if (!i_rst_b)
			fall_q <= 4'hf;
		else if ($fell(i_transmit_clock) || $fell(i_mclk))
			fall_q <= 4'h0;
		else if (fall_q != 4'hf)
			fall_q <= fall_q + 4'h1;
	a_write_answers: assert property (i_axi.awvalid && o_axi.awready &&
		i_axi.wvalid && o_axi.wready |-> ##[1:2] o_axi.bvalid)
		else $error("no write response");
	a_write_done: assert property (o_axi.bvalid && i_axi.bready |=>
		!o_axi.bvalid && o_axi.awready && o_axi.wready)
		else $error("write not closed");
	a_read_answers: assert property (i_axi.arvalid && o_axi.arready
		|-> ##[1:2] o_axi.rvalid)
		else $error("no read response");
	a_read_done: assert property (o_axi.rvalid && i_axi.rready |=>
		!o_axi.rvalid && o_axi.arready)
		else $error("read not closed");
	a_bad_read: assert property (i_axi.arvalid && o_axi.arready &&
		i_axi.araddr > 8'h0c |=> o_axi.rresp == 2'h2 && o_axi.rdata == 0)
		else $error("unmapped read accepted");
	a_tx_strobe: assert property ($changed(o_line_pos) ||
		$changed(o_line_neg) |-> fall_q <= 4'h6)
		else $error("line change without clock fall");
	a_loss_clock: assert property (i_signal_loss [*6] ##1
		$rose(o_rx_clock) |-> $past(i_mclk, 2) || $past(i_mclk, 3) ||
		$past(i_mclk, 4))
		else $error("rx clock not from master");
	a_irq_clear: assert property ($fell(o_irq) |->
		!$past(o_axi.awready) || !$past(o_axi.awready, 2))
		else $error("irq fell without write");
	c_irq: cover property ($rose(o_irq));
	c_loss: cover property (i_signal_loss && $rose(o_rx_clock));
	c_slverr: cover property (o_axi.rvalid && o_axi.rresp == 2'h2);
endmodule
bind t1dp_port t1dp_port_properties #(.IDLE_CYC(IDLE_CYC)) u_props (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_axi(i_axi), .o_axi(o_axi),
	.i_mclk(i_mclk), .i_transmit_clock(i_transmit_clock),
	.i_signal_loss(i_signal_loss), .o_rx_clock(o_rx_clock),
	.o_line_pos(o_line_pos), .o_line_neg(o_line_neg), .o_irq(o_irq));
`default_nettype wire

/* File: verif/test_t1dp_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_t1dp_port
	import t1dp_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic mclk = 1'b0;
	logic run = 1'b1;
	logic loss = 1'b0;
	logic [1:0] fb = 2'b00;
	t1dp_axi_req_s ax = '0;
	t1dp_axi_rsp_s rsp;
	logic transmit_clock, tp, tn, rx_p, rx_n, rx_c, ln_p, ln_n, irq;
	int failures = 0;
	int total_checks = 0;
	int rx_rises = 0;
	int viol_hits = 0;
	int rep, miss, h;
	initial forever #20 clk = !clk;
	initial
	begin
		#7;
		forever #160 mclk = !mclk;
	end
	initial
	begin
		#2000000;
		failures++;
		give_verdict;
	end
	always @(posedge rx_c) rx_rises++;
	always @(posedge clk) if (rx_n === 1'b1) viol_hits++;
	t1dp_port #(.IDLE_CYC(20)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
		.i_ce(1'b1), .i_axi(ax), .o_axi(rsp), .i_mclk(mclk),
		.i_transmit_clock(transmit_clock), .i_tx_positive(tp), .i_tx_negative(tn),
		.o_rx_positive(rx_p), .o_rx_negative(rx_n), .o_rx_clock(rx_c),
		.i_line_clock(1'b0), .i_line_pos(1'b0), .i_line_neg(1'b0),
		.i_signal_loss(loss), .o_line_pos(ln_p), .o_line_neg(ln_n),
		.o_irq(irq));
	t1dp_framer_model u_far (.i_run(run), .i_bits(fb), .o_transmit_clock(transmit_clock),
		.o_pos(tp), .o_neg(tn));
	task give_verdict;
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk_word(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		int n;
		@(posedge clk);
		ax.awaddr <= a;
		ax.wdata <= v;
		ax.wstrb <= 4'hf;
		ax.awvalid <= 1'b1;
		ax.wvalid <= 1'b1;
		ax.bready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (rsp.awready) ax.awvalid <= 1'b0;
			if (rsp.wready) ax.wvalid <= 1'b0;
			if (rsp.bvalid)
			begin
				ax.bready <= 1'b0;
				chk_word({30'h0, rsp.bresp}, {30'h0, r});
				return;
			end
		end
		failures++;
		give_verdict;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		int n;
		@(posedge clk);
		ax.araddr <= a;
		ax.arvalid <= 1'b1;
		ax.rready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (rsp.arready) ax.arvalid <= 1'b0;
			if (rsp.rvalid)
			begin
				ax.rready <= 1'b0;
				chk_word(rsp.rdata & m, e);
				chk_word({30'h0, rsp.rresp}, {30'h0, r});
				return;
			end
		end
		failures++;
		give_verdict;
	endtask
	// Sends n bits, pulse on bit k; counts held polarity and gaps
	task marks(input int n, input int k, input logic [1:0] p,
		input logic [1:0] b);
		int i;
		logic last;
		rep = 0;
		miss = 0;
		last = 1'b0;
		for (i = 0; i < n; i++)
		begin
			if (run)
				@(negedge transmit_clock);
			else
				@(negedge mclk);
			if (i > 2 && ln_p === ln_n)
				miss++;
			else if (i > 2 && ln_p === last)
				rep++;
			last = ln_p;
			@(posedge clk);
			fb <= (i == k) ? p : b;
		end
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h00, 32'hffffffff, 32'h0, 2'h0);
		rd(8'h0c, 32'hffffffff, 32'h0, 2'h0);
		rd(8'h10, 32'hffffffff, 32'h0, 2'h2);
		wr(8'h10, 32'h1f, 2'h2);
		marks(6, 9, 2'b00, 2'b10);
		chk_word(rep, 3);
		chk_bit(ln_p, 1'b1);
		marks(6, 9, 2'b00, 2'b01);
		chk_bit(ln_n, 1'b1);
		rd(8'h04, 32'h1, 32'h1, 2'h0);
		run <= 1'b0;
		repeat (40) @(posedge clk);
		rd(8'h04, 32'h1, 32'h0, 2'h0);
		rd(8'h08, 32'h2, 32'h2, 2'h0);
		chk_bit(irq, 1'b0);
		wr(8'h0c, 32'h2, 2'h0);
		repeat (3) @(posedge clk);
		chk_bit(irq, 1'b1);
		wr(8'h08, 32'h2, 2'h0);
		repeat (3) @(posedge clk);
		chk_bit(irq, 1'b0);
		marks(6, 9, 2'b00, 2'b10);
		chk_word(rep, 3);
		chk_bit(ln_p, 1'b1);
		run <= 1'b1;
		wr(8'h00, 32'h5, 2'h0);
		marks(8, 9, 2'b00, 2'b10);
		chk_word(rep + miss, 0);
		chk_bit(rx_p, 1'b1);
		wr(8'h00, 32'h15, 2'h0);
		marks(4, 9, 2'b00, 2'b10);
		chk_bit(rx_p, 1'b1);
		wr(8'h08, 32'h7, 2'h0);
		marks(6, 9, 2'b00, 2'b10);
		rd(8'h08, 32'h1, 32'h0, 2'h0);
		h = viol_hits;
		marks(8, 3, 2'b11, 2'b10);
		chk_word(rep, 1);
		repeat (16) @(posedge clk);
		rd(8'h08, 32'h1, 32'h1, 2'h0);
		chk_bit(viol_hits != h, 1'b1);
		wr(8'h00, 32'h6, 2'h0);
		marks(8, 9, 2'b00, 2'b00);
		wr(8'h08, 32'h1, 2'h0);
		marks(30, 4, 2'b10, 2'b00);
		rd(8'h08, 32'h1, 32'h0, 2'h0);
		marks(40, 4, 2'b01, 2'b00);
		repeat (16) @(posedge clk);
		rd(8'h08, 32'h1, 32'h1, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		h = rx_rises;
		repeat (40) @(posedge clk);
		chk_word(rx_rises - h, 0);
		loss <= 1'b1;
		repeat (8) @(posedge clk);
		h = rx_rises;
		repeat (64) @(posedge clk);
		chk_bit(rx_rises - h >= 6, 1'b1);
		rd(8'h08, 32'h4, 32'h4, 2'h0);
		wr(8'h00, 32'h8, 2'h0);
		marks(6, 9, 2'b00, 2'b10);
		chk_bit(ln_p, 1'b0);
		give_verdict;
	end
endmodule
`default_nettype wire
